//--- design/hbss_pkg.sv
// package: register map, field positions, reset values and timing for the brake sequencer
package hbss_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF       = 8'h00;
   localparam logic [7:0] STATUS_OFF     = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFF   = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFF   = 8'h0c;
   localparam logic [7:0] LOCK_DLY_OFF   = 8'h10;
   localparam logic [7:0] WAIT_TIME_OFF  = 8'h14;
   localparam logic [7:0] BRK_SPEED_OFF  = 8'h18;
   localparam logic [7:0] TRQ_LIMIT_OFF  = 8'h1c;
   localparam logic [7:0] SPEED_OFF      = 8'h20;

   // ctrl fields
   localparam int CTRL_SW_EN_BIT   = 0;
   localparam int CTRL_T2_ZS_BIT   = 1;
   localparam int CTRL_T2_MODE_LSB = 1;

   // irq bits
   localparam int IRQ_ALARM_BIT   = 0;
   localparam int IRQ_BRAKE_BIT   = 1;
   localparam int IRQ_POWER_BIT   = 2;
   localparam int IRQ_WIDTH       = 3;

   // reset values
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [15:0] LOCK_DLY_RST  = 16'h0000;
   localparam logic [15:0] WAIT_TIME_RST = 16'h0032;
   localparam logic [15:0] BRK_SPEED_RST = 16'h001e;
   localparam logic [15:0] TRQ_LIMIT_RST = 16'h0320;

   // timing: delays are counted in units of 1 ms
   localparam int CLK_HZ        = 25_000_000;
   localparam int TICK_US       = 1000;
   localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;

   typedef enum logic [1:0] {
      HBSS_ALM_NONE,
      HBSS_ALM_TYPE1,
      HBSS_ALM_TYPE2
   } hbss_alarm_t;

   typedef enum logic [0:0] {
      HBSS_T2_AS_OFF,
      HBSS_T2_ZERO_SPEED
   } hbss_t2_mode_t;
endpackage : hbss_pkg

//--- design/hbss_sync.sv
// three-flop synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module hbss_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q     <= RST_VAL;
         s2_q     <= RST_VAL;
         s3_q     <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // change only once second and third stage agree
         if (s2_q == s3_q) begin
            sync_out <= s3_q;
         end
      end
   end
endmodule : hbss_sync

//--- design/hbss_timer.sv
// millisecond down-counter: load, run, expire pulse
`timescale 1ns/1ps
module hbss_timer #(
   parameter int TICK_CYCLES = 25000,
   parameter int CNT_W       = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             start,
   input  wire logic             stop,
   input  wire logic [CNT_W-1:0] load_ms,
   output logic                  running,
   output logic                  expired
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   logic [PW-1:0]    pre_q;
   logic [CNT_W-1:0] ms_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q   <= '0;
         ms_q    <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (stop) begin
            running <= 1'b0;
         end else if (start) begin
            pre_q <= '0;
            ms_q  <= load_ms;
            // zero delay expires on the next edge
            if (load_ms == '0) begin
               expired <= 1'b1;
               running <= 1'b0;
            end else begin
               running <= 1'b1;
            end
         end else if (running) begin
            if (pre_q == PRE_LAST) begin
               pre_q <= '0;
               if (ms_q == CNT_W'(1)) begin
                  running <= 1'b0;
                  expired <= 1'b1;
               end
               ms_q <= ms_q - CNT_W'(1);
            end else begin
               pre_q <= pre_q + PW'(1);
            end
         end
      end
   end
endmodule : hbss_timer

//--- design/hbss_top.sv
// holding brake and motor power stop sequencer with apb registers
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - type 2 alarms may choose a zero speed stop, using the stop torque limit while stopping.
// - an alarm while rotating stops the motor and drops the brake output so the brake engages.
// - after power is removed while rotating, brake drops once speed is below brake command speed.
// - after power is removed while rotating, brake drops once the off-to-brake wait time elapses.
// - at standstill the brake drops one cycle after the synchronised drive enable goes inactive.
// - at standstill motor power stays on for the lock delay after enable drops, then goes off.
// - an alarm while stopped and locked removes motor power at once, skipping the lock delay.
module hbss_top
   import hbss_pkg::*;
#(
   parameter int SPD_W       = 16,
   parameter int TICK_CYCLES = hbss_pkg::TICK_CYCLES
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 drive_enable_in,
   input  wire hbss_pkg::hbss_alarm_t alarm_class,
   input  wire logic [SPD_W-1:0]     motor_speed,
   output logic                      brake_release_out,
   output logic                      motor_power_en,
   output logic                      zero_speed_stop,
   output logic [15:0]               torque_limit_out,
   output logic                      irq
);
   import hbss_pkg::*;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_RUN,
      ST_ZS_STOP,
      ST_ROT_WAIT,
      ST_LOCK_HOLD
   } hbss_state_t;

   hbss_state_t state_q;

   logic [31:0]          ctrl_q;
   logic [15:0]          lock_deenergize_delay_q;
   logic [15:0]          off_to_brake_wait_time_q;
   logic [SPD_W-1:0]     brake_command_speed_q;
   logic [15:0]          stop_torque_limit_q;
   logic [IRQ_WIDTH-1:0] irq_stat_q;
   logic [IRQ_WIDTH-1:0] irq_mask_q;
   logic [31:0]          prdata_d;
   logic                 en_pin_s;
   logic                 enable;
   logic                 alarm;
   logic                 alarm_q;
   logic                 brake_q;
   logic                 power_q;
   logic                 rotating;
   logic                 tmr_start;
   logic                 tmr_stop;
   logic [15:0]          tmr_load;
   logic                 tmr_running;
   logic                 tmr_expired;
   logic                 wr_en;
   logic                 rd_en;

   // external enable pin crosses from outside the clock domain
   hbss_sync #(
      .RST_VAL (1'b0)
   ) u_en_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (drive_enable_in),
      .sync_out (en_pin_s)
   );

   assign enable   = en_pin_s & ctrl_q[CTRL_SW_EN_BIT];
   assign alarm    = (alarm_class != HBSS_ALM_NONE);
   assign rotating = (motor_speed >= brake_command_speed_q);

   // apb: zero wait states, never errors
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;

   always_comb begin
      prdata_d = 32'h0000_0000;
      case (paddr)
         CTRL_OFF:      prdata_d = ctrl_q;
         STATUS_OFF:    prdata_d = {24'h00_0000, 1'b0, state_q, alarm, enable,
                                    power_q, brake_q};
         IRQ_STAT_OFF:  prdata_d = {{(32-IRQ_WIDTH){1'b0}}, irq_stat_q};
         IRQ_MASK_OFF:  prdata_d = {{(32-IRQ_WIDTH){1'b0}}, irq_mask_q};
         LOCK_DLY_OFF:  prdata_d = {16'h0000, lock_deenergize_delay_q};
         WAIT_TIME_OFF: prdata_d = {16'h0000, off_to_brake_wait_time_q};
         BRK_SPEED_OFF: prdata_d = 32'(brake_command_speed_q);
         TRQ_LIMIT_OFF: prdata_d = {16'h0000, stop_torque_limit_q};
         SPEED_OFF:     prdata_d = 32'(motor_speed);
         default:       prdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= prdata_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q                   <= CTRL_RST;
         lock_deenergize_delay_q  <= LOCK_DLY_RST;
         off_to_brake_wait_time_q <= WAIT_TIME_RST;
         brake_command_speed_q    <= SPD_W'(BRK_SPEED_RST);
         stop_torque_limit_q      <= TRQ_LIMIT_RST;
         irq_mask_q               <= '0;
      end else if (wr_en) begin
         case (paddr)
            CTRL_OFF:      ctrl_q                   <= {30'h0, pwdata[1:0]};
            IRQ_MASK_OFF:  irq_mask_q               <= pwdata[IRQ_WIDTH-1:0];
            LOCK_DLY_OFF:  lock_deenergize_delay_q  <= pwdata[15:0];
            WAIT_TIME_OFF: off_to_brake_wait_time_q <= pwdata[15:0];
            BRK_SPEED_OFF: brake_command_speed_q    <= pwdata[SPD_W-1:0];
            TRQ_LIMIT_OFF: stop_torque_limit_q      <= pwdata[15:0];
            default:       ;
         endcase
      end
   end

   // delay timer shared by lock delay and off-to-brake wait
   hbss_timer #(
      .TICK_CYCLES (TICK_CYCLES),
      .CNT_W       (16)
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (tmr_start),
      .stop    (tmr_stop),
      .load_ms (tmr_load),
      .running (tmr_running),
      .expired (tmr_expired)
   );

   always_comb begin
      tmr_start = 1'b0;
      tmr_stop  = 1'b0;
      tmr_load  = off_to_brake_wait_time_q;
      case (state_q)
         ST_RUN: begin
            if (alarm || !enable) begin
               if (rotating) begin
                  tmr_start = !(alarm && alarm_class == HBSS_ALM_TYPE2 &&
                                ctrl_q[CTRL_T2_ZS_BIT]);
                  tmr_load  = off_to_brake_wait_time_q;
               end else if (!alarm) begin
                  tmr_start = 1'b1;
                  tmr_load  = lock_deenergize_delay_q;
               end
            end
         end
         ST_ZS_STOP: begin
            // zero speed reached: hand over to the rotating wait
            tmr_start = !rotating;
            tmr_load  = off_to_brake_wait_time_q;
         end
         ST_LOCK_HOLD: tmr_stop = alarm;
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OFF;
         brake_q <= 1'b0;
         power_q <= 1'b0;
      end else begin
         case (state_q)
            ST_OFF: begin
               if (enable && !alarm) begin
                  state_q <= ST_RUN;
                  power_q <= 1'b1;
                  brake_q <= 1'b1;
               end
            end
            ST_RUN: begin
               if (alarm || !enable) begin
                  if (rotating) begin
                     if (alarm && alarm_class == HBSS_ALM_TYPE2 &&
                         ctrl_q[CTRL_T2_ZS_BIT]) begin
                        state_q <= ST_ZS_STOP;
                     end else begin
                        // power off, brake held until speed or timer
                        state_q <= ST_ROT_WAIT;
                        power_q <= 1'b0;
                     end
                  end else begin
                     brake_q <= 1'b0;
                     if (alarm) begin
                        state_q <= ST_OFF;
                        power_q <= 1'b0;
                     end else begin
                        state_q <= ST_LOCK_HOLD;
                     end
                  end
               end
            end
            ST_ZS_STOP: begin
               // decelerate under power to zero speed, then release power
               if (!rotating) begin
                  state_q <= ST_ROT_WAIT;
                  power_q <= 1'b0;
               end
            end
            ST_ROT_WAIT: begin
               // first of speed threshold or wait expiry
               if (!rotating || tmr_expired) begin
                  brake_q <= 1'b0;
                  state_q <= ST_OFF;
               end
            end
            ST_LOCK_HOLD: begin
               if (alarm) begin
                  power_q <= 1'b0;
                  state_q <= ST_OFF;
               end else if (tmr_expired) begin
                  power_q <= 1'b0;
                  state_q <= ST_OFF;
               end
            end
            default: begin
               state_q <= ST_OFF;
               brake_q <= 1'b0;
               power_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_speed_stop  <= 1'b0;
         torque_limit_out <= 16'h0000;
      end else begin
         zero_speed_stop  <= (state_q == ST_ZS_STOP);
         // stop torque limit applies only in zero speed stop
         torque_limit_out <= (state_q == ST_ZS_STOP) ? stop_torque_limit_q : 16'h0000;
      end
   end

   assign brake_release_out = brake_q;
   assign motor_power_en    = power_q;

   // interrupts: set wins over write-one clear
   logic                 brake_prev_q;
   logic                 power_prev_q;
   logic [IRQ_WIDTH-1:0] irq_set;
   assign irq_set[IRQ_ALARM_BIT] = alarm & ~alarm_q;
   assign irq_set[IRQ_BRAKE_BIT] = brake_prev_q & ~brake_q;
   assign irq_set[IRQ_POWER_BIT] = power_prev_q & ~power_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_q      <= 1'b0;
         brake_prev_q <= 1'b0;
         power_prev_q <= 1'b0;
         irq_stat_q   <= '0;
         irq          <= 1'b0;
      end else begin
         alarm_q      <= alarm;
         brake_prev_q <= brake_q;
         power_prev_q <= power_q;
         irq_stat_q   <= (irq_stat_q & ~((wr_en && paddr == IRQ_STAT_OFF) ?
                         pwdata[IRQ_WIDTH-1:0] : '0)) | irq_set;
         irq          <= |(irq_stat_q & irq_mask_q);
      end
   end

   logic unused_rd;
   assign unused_rd = rd_en | tmr_running;
endmodule : hbss_top

//--- sim/hbss_chk_asserts.sv
// checker: port-level assertions of the brake stop sequencer
`timescale 1ns/1ps
module hbss_chk
   import hbss_pkg::*;
(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire hbss_pkg::hbss_alarm_t alarm_class,
   input wire logic                  brake_release_out,
   input wire logic                  motor_power_en,
   input wire logic                  zero_speed_stop,
   input wire logic [15:0]           torque_limit_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_power_cut;
      $fell(motor_power_en) && brake_release_out;
   endsequence
   sequence s_lock_start;
      $fell(brake_release_out) && motor_power_en;
   endsequence
   a_apb_no_wait: assert property (pready && !pslverr)
      else $error("apb wait state or error seen");
   a_alarm_cuts_power: assert property (motor_power_en && brake_release_out &&
      !zero_speed_stop && alarm_class == HBSS_ALM_TYPE1 |=> !motor_power_en)
      else $error("alarm left motor powered");
   a_lock_alarm_off: assert property (motor_power_en && !brake_release_out &&
      alarm_class != HBSS_ALM_NONE |=> !motor_power_en)
      else $error("alarm left locked motor powered");
   a_rot_brake_bound: assert property (s_power_cut |-> ##[1:1000] !brake_release_out)
      else $error("brake never engaged after power cut");
   a_lock_power_off: assert property (s_lock_start |-> ##[1:1000] !motor_power_en)
      else $error("lock hold never removed power");
   a_lock_brake_held: assert property (s_lock_start |=> !brake_release_out [*2])
      else $error("brake released again during lock hold");
   a_brake_needs_power: assert property ($rose(brake_release_out) |-> motor_power_en)
      else $error("brake released without motor power");
   a_zs_powered: assert property ($rose(zero_speed_stop) |-> motor_power_en)
      else $error("zero speed stop without power");
   a_zs_torque: assert property (zero_speed_stop [*2] |-> torque_limit_out != 16'h0)
      else $error("no torque limit in zero speed stop");
   a_torque_idle: assert property (!zero_speed_stop [*3] |-> torque_limit_out == 16'h0)
      else $error("torque limit outside zero speed stop");
   a_zs_brake_after: assert property ($fell(motor_power_en) && zero_speed_stop
      |-> ##[1:2] !brake_release_out)
      else $error("brake late after zero speed stop");
endmodule : hbss_chk

bind hbss_top hbss_chk u_hbss_chk (.pclk(pclk), .presetn(presetn), .pready(pready),
   .pslverr(pslverr), .alarm_class(alarm_class), .brake_release_out(brake_release_out),
   .motor_power_en(motor_power_en), .zero_speed_stop(zero_speed_stop),
   .torque_limit_out(torque_limit_out));

//--- sim/hbss_plant.sv
// model of motor shaft and holding brake relay behind the sequencer
`timescale 1ns/1ps
module hbss_plant #(
   parameter int BRK_CYCLES = 3
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        motor_power_en,
   input  wire logic        brake_release_out,
   input  wire logic        zero_speed_stop,
   input  wire logic [15:0] target,
   input  wire logic [15:0] decel,
   output logic [15:0]      motor_speed,
   output logic             brake_open
);
   int cnt_q;
   // armature lags the command both ways
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         brake_open <= 1'b0;
      end else if (brake_release_out == brake_open) begin
         cnt_q <= 0;
      end else if (cnt_q == BRK_CYCLES - 1) begin
         brake_open <= brake_release_out;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
   // an engaged brake holds the shaft at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) motor_speed <= 16'h0;
      else if (!brake_open) motor_speed <= 16'h0;
      else if (motor_power_en && !zero_speed_stop) motor_speed <= target;
      else if (motor_speed > decel) motor_speed <= motor_speed - decel;
      else motor_speed <= 16'h0;
   end
endmodule : hbss_plant

//--- sim/tb_top.sv
// testbench: registers, interrupt and stop sequences of the brake sequencer
`timescale 1ns/1ps
module tb_top;
   import hbss_pkg::*;
   localparam int TK = 4;
   logic        pclk, presetn, psel, penable, pwrite, drive_enable_in, pready, pslverr;
   logic        brake_release_out, motor_power_en, zero_speed_stop, irq, brake_open;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d, t;
   logic [15:0] motor_speed, torque_limit_out, target, decel;
   hbss_alarm_t alarm_class;
   int          num_errors, total_checks, seed, n;

   hbss_top #(.TICK_CYCLES(TK)) u_hbss_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drive_enable_in(drive_enable_in),
      .alarm_class(alarm_class), .motor_speed(motor_speed), .irq(irq),
      .brake_release_out(brake_release_out), .motor_power_en(motor_power_en),
      .zero_speed_stop(zero_speed_stop), .torque_limit_out(torque_limit_out));
   hbss_plant u_hbss_plant (.pclk(pclk), .presetn(presetn), .motor_power_en(motor_power_en),
      .brake_release_out(brake_release_out), .zero_speed_stop(zero_speed_stop),
      .target(target), .decel(decel), .motor_speed(motor_speed), .brake_open(brake_open));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         chk(1'b0, "apb timeout");
         conclude();
      end
      d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(d === e, m);
   endtask : rdc

   // sel 1 waits for power off, 0 for brake engaged
   task automatic wait_low(input logic sel, output int c);
      c = 0;
      while ((sel ? motor_power_en : brake_release_out) !== 1'b0 && c < 2000) begin
         @(posedge pclk);
         c++;
      end
      if (c >= 2000) begin
         chk(1'b0, "output wait timeout");
         conclude();
      end
   endtask : wait_low

   task automatic start(input logic [15:0] spd);
      int c;
      drive_enable_in <= 1'b0;
      target <= 16'h0;
      repeat (6) @(posedge pclk);
      // alarm cleared only once the synchronised enable is low, else a stray restart
      alarm_class <= HBSS_ALM_NONE;
      drive_enable_in <= 1'b1;
      c = 0;
      while (brake_open !== 1'b1 && c < 200) begin
         @(posedge pclk);
         c++;
      end
      chk(brake_open === 1'b1, "brake never opened");
      target <= spd; // motion only once the brake is open
      repeat (3) @(posedge pclk);
   endtask : start

   initial begin
      seed = 32'h9f4afc26;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      drive_enable_in = 1'b0;
      alarm_class = HBSS_ALM_NONE;
      target = 16'h0;
      decel = 16'h1;
      num_errors = 0;
      total_checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(CTRL_OFF, CTRL_RST, "ctrl reset");
      rdc(STATUS_OFF, 32'h0, "status reset");
      rdc(LOCK_DLY_OFF, {16'h0, LOCK_DLY_RST}, "lock delay reset");
      rdc(WAIT_TIME_OFF, {16'h0, WAIT_TIME_RST}, "wait reset");
      rdc(BRK_SPEED_OFF, {16'h0, BRK_SPEED_RST}, "brake speed reset");
      rdc(TRQ_LIMIT_OFF, {16'h0, TRQ_LIMIT_RST}, "torque reset");
      rdc(8'h24, 32'h0, "unmapped read");
      apb(1'b1, SPEED_OFF, 32'hffff);
      rdc(SPEED_OFF, 32'h0, "speed read only");
      t = 32'h100 + ($random(seed) & 32'hfff);
      apb(1'b1, TRQ_LIMIT_OFF, t);
      apb(1'b1, CTRL_OFF, 32'h1);
      // alarm while rotating, brake follows speed
      decel <= 16'd5;
      start(16'd100 + 16'($random(seed) & 32'h3f));
      alarm_class <= HBSS_ALM_TYPE1;
      wait_low(1'b1, n);
      chk(n <= 2 && brake_release_out === 1'b1, "alarm power cut");
      wait_low(1'b0, n);
      chk(motor_speed < 16'd30 && motor_speed > 16'd10 && n < 200, "speed drop");
      // slow decel, wait timer wins
      apb(1'b1, WAIT_TIME_OFF, 32'h2);
      decel <= 16'd1;
      start(16'd300 + 16'($random(seed) & 32'hff));
      alarm_class <= HBSS_ALM_TYPE2;
      wait_low(1'b1, n);
      wait_low(1'b0, n);
      chk(n > TK && n <= 2 * TK + 4 && motor_speed >= 16'd30, "wait expiry");
      // standstill, enable removed
      apb(1'b1, LOCK_DLY_OFF, 32'h3);
      start(16'd0);
      drive_enable_in <= 1'b0;
      wait_low(1'b0, n);
      chk(motor_power_en === 1'b1, "brake with enable off");
      wait_low(1'b1, n);
      chk(n > 2 * TK && n <= 3 * TK + 4, "lock delay");
      // standstill alarm skips the lock delay
      start(16'd0);
      alarm_class <= HBSS_ALM_TYPE1;
      wait_low(1'b0, n);
      chk(motor_power_en === 1'b0, "locked alarm");
      // alarm inside the lock delay cuts power before the delay ends
      start(16'd0);
      drive_enable_in <= 1'b0;
      wait_low(1'b0, n);
      alarm_class <= HBSS_ALM_TYPE1;
      wait_low(1'b1, n);
      chk(n > 0 && n <= 2, "lock hold alarm");
      // type 2 alarm with zero speed stop chosen
      apb(1'b1, CTRL_OFF, 32'h3);
      decel <= 16'd4;
      start(16'd200);
      alarm_class <= HBSS_ALM_TYPE2;
      repeat (3) @(posedge pclk);
      chk(zero_speed_stop === 1'b1 && motor_power_en === 1'b1, "zero speed entry");
      chk(torque_limit_out === t[15:0], "stop torque limit");
      wait_low(1'b1, n);
      chk(brake_release_out === 1'b1 && motor_speed < 16'd30, "zero speed reached");
      wait_low(1'b0, n);
      chk(n <= 2, "brake after zero speed");
      // interrupt: masked, unmasked, cleared
      alarm_class <= HBSS_ALM_NONE;
      chk(irq === 1'b0, "masked irq");
      apb(1'b0, IRQ_STAT_OFF, 32'h0);
      chk(d[IRQ_ALARM_BIT] === 1'b1, "alarm irq status");
      apb(1'b1, IRQ_MASK_OFF, 32'h1 << IRQ_ALARM_BIT);
      repeat (2) @(posedge pclk);
      chk(irq === 1'b1, "irq raised");
      apb(1'b1, IRQ_STAT_OFF, 32'h7);
      repeat (2) @(posedge pclk);
      chk(irq === 1'b0, "irq cleared");
      conclude();
   end
endmodule : tb_top
